// ---- bscd_params.svh ----
`ifndef BSCD_PARAMS_SVH
`define BSCD_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define BSCD_OFS_GENERAL_CTRL 4'h0
`define BSCD_OFS_STRAP_STATUS 4'h1
`define BSCD_OFS_READY        4'h2

// ----------------------------------------
// General control field positions
// ----------------------------------------
`define BSCD_GC_SFM_BIT  0
`define BSCD_GC_BOOT_BIT 1
`define BSCD_GC_HOLD_BIT 2
`define BSCD_GC_BE_BIT   3
`define BSCD_GC_MGMT_BIT 4

// ----------------------------------------
// Boot codes
// ----------------------------------------
`define BSCD_CODE_LE_FLASH 4'h0
`define BSCD_CODE_PCIE_P10 4'h1
`define BSCD_CODE_PCIE_P6  4'h2
`define BSCD_CODE_PCIE_P0  4'h3
`define BSCD_CODE_NPI9_P10 4'h4
`define BSCD_CODE_NPI9     4'h5
`define BSCD_CODE_NPI4     4'h8
`define BSCD_CODE_PCIE     4'h9
`define BSCD_CODE_MGMT_A0  4'hA
`define BSCD_CODE_MGMT_A31 4'hB
`define BSCD_CODE_BE_FLASH 4'hC
`define BSCD_CODE_NONE     4'hF

// ----------------------------------------
// Reference frequency codes
// ----------------------------------------
`define BSCD_REF_125  3'h0
`define BSCD_REF_156  3'h1
`define BSCD_REF_250  3'h2
`define BSCD_REF_25   3'h4

// ----------------------------------------
// Reset values
// ----------------------------------------
`define BSCD_GC_RST_IDLE 5'h04
`define BSCD_GC_RST_LE   5'h03
`define BSCD_GC_RST_BE   5'h0B
`define BSCD_GC_RST_MGMT 5'h14
`define BSCD_OE_N_IDLE   2'h3

`define BSCD_MGMT_ADDR_LO 5'h00
`define BSCD_MGMT_ADDR_HI 5'h1F
`define BSCD_CAPTURE_CYCLES 3'h3

`endif

// ---- bscd_pkg.sv ----
`default_nettype none

package bscd_pkg;

    typedef enum logic [1:0] {
        BSCD_ST_RESET,
        BSCD_ST_SETTLE,
        BSCD_ST_RUN
    } bscd_state_t;

    typedef enum logic [2:0] {
        BSCD_REF_F125,
        BSCD_REF_F156P25,
        BSCD_REF_F250,
        BSCD_REF_F25,
        BSCD_REF_RESERVED
    } bscd_ref_t;

    typedef struct packed {
        bscd_state_t state;
        logic [2:0]  settle_cnt;
        logic [3:0]  boot_code;
        logic        pll_sel;
        logic [2:0]  main_ref;
        logic [2:0]  second_ref;
        logic [4:0]  gen_ctrl;
        logic        strap_sync1_sel;
        logic [3:0]  strap_sync1_boot;
        logic [2:0]  strap_sync1_mref;
        logic [2:0]  strap_sync1_sref;
        logic        strap_sync2_sel;
        logic [3:0]  strap_sync2_boot;
        logic [2:0]  strap_sync2_mref;
        logic [2:0]  strap_sync2_sref;
        logic [1:0]  ready_sync1;
        logic [1:0]  ready_sync2;
        logic        tap_sync1;
        logic        tap_sync2;
        logic        cfg_valid;
        logic        strap_route;
        logic        second_pll_clk;
        logic        second_pll_pwr;
        bscd_ref_t   second_ref_dec;
        logic        pcie_en;
        logic        front_p10_sfi;
        logic        front_p6_sgmii;
        logic        front_p0_sgmii;
        logic        npi4_sgmii;
        logic        npi9_sfi;
        logic        reg_frames;
        logic        serial_slave_en;
        logic        mgmt_slave_en;
        logic [4:0]  mgmt_addr;
        logic        cpu_run;
        logic        cpu_be;
        logic        boot_map;
        logic        sfm_en;
        logic        tap_boundary;
        logic [1:0]  strap_hi_drive;
        logic [1:0]  strap_hi_oe_n;
        logic [31:0] rdata;
    } bscd_state_s_t;

endpackage

`default_nettype wire

// ---- bscd_top.sv ----
// Added by the designer: the register addresses and strobed register access.
`default_nettype none
`include "bscd_params.svh"

module bscd_top (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        second_pll_select_strap_in,
    input  wire logic [2:0]  main_pll_ref_freq_strap_in,
    input  wire logic [2:0]  second_pll_ref_freq_strap_in,
    input  wire logic [3:0]  boot_strap_in,
    input  wire logic [1:0]  port_ready_in,
    input  wire logic        debug_tap_select_n_in,
    input  wire logic [3:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [31:0]      reg_rdata_out,
    output logic             config_valid_out,
    output logic             strap_pins_released_out,
    output logic             second_pll_clock_select_out,
    output logic             second_pll_power_out,
    output bscd_pkg::bscd_ref_t second_pll_ref_out,
    output logic [2:0]       main_pll_ref_out,
    output logic             pcie_enable_out,
    output logic             front_port10_sfi_out,
    output logic             front_port6_sgmii_out,
    output logic             front_port0_sgmii_out,
    output logic             npi_port4_sgmii_out,
    output logic             npi_port9_sfi_out,
    output logic             register_access_frames_out,
    output logic             serial_slave_enable_out,
    output logic             management_slave_enable_out,
    output logic [4:0]       management_slave_addr_out,
    output logic             cpu_run_out,
    output logic             cpu_big_endian_out,
    output logic             boot_map_enable_out,
    output logic             serial_flash_master_out,
    output logic             tap_boundary_scan_out,
    output logic [1:0]       boot_strap_hi_out,
    output logic [1:0]       boot_strap_hi_oe_n_out
);
    import bscd_pkg::*;

    bscd_state_s_t s_reg;
    bscd_state_s_t s_next;
    logic          port_or_pcie;
    logic          ready_any;

    // ----------------------------------------
    // Boot code to general control reset value
    // ----------------------------------------
    function automatic logic [4:0] gc_from_code(input logic [3:0] c);
        logic [4:0] g;
        g = `BSCD_GC_RST_IDLE;
        if (c == `BSCD_CODE_LE_FLASH) begin
            g = `BSCD_GC_RST_LE;
        end else if (c == `BSCD_CODE_BE_FLASH) begin
            g = `BSCD_GC_RST_BE;
        end else if (c == `BSCD_CODE_MGMT_A0 || c == `BSCD_CODE_MGMT_A31) begin
            g = `BSCD_GC_RST_MGMT;
        end
        return g;
    endfunction

    always_comb begin
        port_or_pcie = (s_reg.boot_code inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9});
        ready_any    = |s_reg.ready_sync2;
    end

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.strap_sync1_sel  = second_pll_select_strap_in;
        s_next.strap_sync1_boot = boot_strap_in;
        s_next.strap_sync1_mref = main_pll_ref_freq_strap_in;
        s_next.strap_sync1_sref = second_pll_ref_freq_strap_in;
        s_next.strap_sync2_sel  = s_reg.strap_sync1_sel;
        s_next.strap_sync2_boot = s_reg.strap_sync1_boot;
        s_next.strap_sync2_mref = s_reg.strap_sync1_mref;
        s_next.strap_sync2_sref = s_reg.strap_sync1_sref;
        s_next.ready_sync1      = port_ready_in;
        s_next.ready_sync2      = s_reg.ready_sync1;
        s_next.tap_sync1        = debug_tap_select_n_in;
        s_next.tap_sync2        = s_reg.tap_sync1;
        s_next.rdata            = 32'h0000_0000;

        case (s_reg.state)
            BSCD_ST_RESET: begin
                s_next.state      = BSCD_ST_SETTLE;
                s_next.settle_cnt = 3'h0;
            end
            BSCD_ST_SETTLE: begin
                // Wait until the synchroniser holds post-release pin values.
                if (s_reg.settle_cnt == `BSCD_CAPTURE_CYCLES) begin
                    s_next.boot_code   = s_reg.strap_sync2_boot;
                    s_next.pll_sel     = s_reg.strap_sync2_sel;
                    s_next.main_ref    = s_reg.strap_sync2_mref;
                    s_next.second_ref  = s_reg.strap_sync2_sref;
                    s_next.gen_ctrl    = gc_from_code(s_reg.strap_sync2_boot);
                    s_next.state       = BSCD_ST_RUN;
                end else begin
                    s_next.settle_cnt = s_reg.settle_cnt + 3'h1;
                end
            end
            BSCD_ST_RUN: begin
                s_next.cfg_valid   = 1'b1;
                s_next.strap_route = 1'b1;
                // Writes count only once the captured configuration is visible.
                if (s_reg.cfg_valid && reg_wr_in && reg_addr_in == `BSCD_OFS_GENERAL_CTRL) begin
                    s_next.gen_ctrl = reg_wdata_in[4:0];
                end
            end
            default: begin
                s_next.state = BSCD_ST_RESET;
            end
        endcase

        if (reg_rd_in) begin
            case (reg_addr_in)
                `BSCD_OFS_GENERAL_CTRL: s_next.rdata = {27'h0, s_reg.gen_ctrl};
                `BSCD_OFS_STRAP_STATUS: s_next.rdata = {21'h0, s_reg.second_ref, s_reg.main_ref,
                                                        s_reg.pll_sel, s_reg.boot_code};
                `BSCD_OFS_READY:        s_next.rdata = {29'h0, s_reg.strap_hi_drive != 2'h0, s_reg.cfg_valid,
                                                        s_reg.tap_boundary};
                default:                s_next.rdata = 32'h0000_0000;
            endcase
        end

        // Decoded outputs other than the debug port routing stay inactive until capture completes.
        if (s_reg.cfg_valid) begin
            s_next.second_pll_clk = s_reg.pll_sel;
            s_next.second_pll_pwr = s_reg.pll_sel;
            case (s_reg.second_ref)
                `BSCD_REF_125: s_next.second_ref_dec = BSCD_REF_F125;
                `BSCD_REF_156: s_next.second_ref_dec = BSCD_REF_F156P25;
                `BSCD_REF_250: s_next.second_ref_dec = BSCD_REF_F250;
                `BSCD_REF_25:  s_next.second_ref_dec = BSCD_REF_F25;
                default:       s_next.second_ref_dec = BSCD_REF_RESERVED;
            endcase
            if (!s_reg.pll_sel) begin
                s_next.second_ref_dec = BSCD_REF_F125;
            end
            s_next.pcie_en        = port_or_pcie;
            s_next.front_p10_sfi  = s_reg.boot_code inside {`BSCD_CODE_PCIE_P10, `BSCD_CODE_NPI9_P10};
            s_next.front_p6_sgmii = s_reg.boot_code == `BSCD_CODE_PCIE_P6;
            s_next.front_p0_sgmii = s_reg.boot_code == `BSCD_CODE_PCIE_P0;
            s_next.npi4_sgmii     = s_reg.boot_code inside {4'h1, 4'h2, 4'h3, `BSCD_CODE_NPI4};
            s_next.npi9_sfi       = s_reg.boot_code inside {`BSCD_CODE_NPI9_P10, `BSCD_CODE_NPI9};
            s_next.reg_frames     = s_reg.boot_code inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8};
            s_next.mgmt_addr      = (s_reg.boot_code == `BSCD_CODE_MGMT_A31) ? `BSCD_MGMT_ADDR_HI
                                                                              : `BSCD_MGMT_ADDR_LO;
            s_next.mgmt_slave_en  = s_reg.gen_ctrl[`BSCD_GC_MGMT_BIT];
            s_next.sfm_en         = s_reg.gen_ctrl[`BSCD_GC_SFM_BIT];
            s_next.serial_slave_en = !s_reg.gen_ctrl[`BSCD_GC_SFM_BIT];
            s_next.boot_map       = s_reg.gen_ctrl[`BSCD_GC_BOOT_BIT];
            s_next.cpu_run        = !s_reg.gen_ctrl[`BSCD_GC_HOLD_BIT];
            s_next.cpu_be         = s_reg.gen_ctrl[`BSCD_GC_BE_BIT];
            if (port_or_pcie && ready_any) begin
                s_next.strap_hi_drive = 2'h3;
                s_next.strap_hi_oe_n  = 2'h0;
            end
        end
        s_next.tap_boundary = s_reg.tap_sync2;
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            s_reg <= '0;
            s_reg.gen_ctrl <= `BSCD_GC_RST_IDLE;
            s_reg.strap_hi_oe_n <= `BSCD_OE_N_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    always_comb begin
        reg_rdata_out               = s_reg.rdata;
        config_valid_out            = s_reg.cfg_valid;
        strap_pins_released_out     = s_reg.strap_route;
        second_pll_clock_select_out = s_reg.second_pll_clk;
        second_pll_power_out        = s_reg.second_pll_pwr;
        second_pll_ref_out          = s_reg.second_ref_dec;
        main_pll_ref_out            = s_reg.main_ref;
        pcie_enable_out             = s_reg.pcie_en;
        front_port10_sfi_out        = s_reg.front_p10_sfi;
        front_port6_sgmii_out       = s_reg.front_p6_sgmii;
        front_port0_sgmii_out       = s_reg.front_p0_sgmii;
        npi_port4_sgmii_out         = s_reg.npi4_sgmii;
        npi_port9_sfi_out           = s_reg.npi9_sfi;
        register_access_frames_out  = s_reg.reg_frames;
        serial_slave_enable_out     = s_reg.serial_slave_en;
        management_slave_enable_out = s_reg.mgmt_slave_en;
        management_slave_addr_out   = s_reg.mgmt_addr;
        cpu_run_out                 = s_reg.cpu_run;
        cpu_big_endian_out          = s_reg.cpu_be;
        boot_map_enable_out         = s_reg.boot_map;
        serial_flash_master_out     = s_reg.sfm_en;
        tap_boundary_scan_out       = s_reg.tap_boundary;
        boot_strap_hi_out           = s_reg.strap_hi_drive;
        boot_strap_hi_oe_n_out      = s_reg.strap_hi_oe_n;
    end

endmodule

`default_nettype wire

// ---- bscd_port_model.sv ----
`default_nettype none
// ----------------------------------------
// Port logic that reports link readiness
// ----------------------------------------
module bscd_port_model #(
    parameter int DLY = 4
) (
    input  wire logic  mclk_in,
    input  wire logic  rst_n_in,
    input  wire logic  link_up_in,
    output logic [1:0] ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    // A port is usable only some cycles after the device brings it up.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cnt       <= 0;
            ready_out <= 2'h0;
        end else if (link_up_in) begin
            cnt <= cnt + 1;
            if (cnt == DLY) ready_out <= 2'h1;
        end
    end
endmodule
`default_nettype wire

// ---- bscd_top_assertions.sv ----
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module bscd_top_assertions
    import bscd_pkg::*;
(
    input wire logic              mclk_in,
    input wire logic              rst_n_in,
    input wire logic              debug_tap_select_n_in,
    input wire logic [3:0]        reg_addr_in,
    input wire logic [31:0]       reg_wdata_in,
    input wire logic              reg_wr_in,
    input wire logic              reg_rd_in,
    input wire logic [31:0]       reg_rdata_out,
    input wire logic              config_valid_out,
    input wire logic              strap_pins_released_out,
    input wire logic              second_pll_clock_select_out,
    input wire logic              second_pll_power_out,
    input wire bscd_pkg::bscd_ref_t second_pll_ref_out,
    input wire logic              serial_slave_enable_out,
    input wire logic              serial_flash_master_out,
    input wire logic              management_slave_enable_out,
    input wire logic              tap_boundary_scan_out,
    input wire logic [1:0]        boot_strap_hi_out,
    input wire logic [1:0]        boot_strap_hi_oe_n_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] up_cnt;
    // Saturating count of cycles since reset left, so decoded levels are settled.
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) up_cnt <= 3'h0;
        else if (up_cnt != 3'h7) up_cnt <= up_cnt + 3'h1;
    end
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_wr_ctrl;
        reg_wr_in && reg_addr_in == 4'h0 && config_valid_out;
    endsequence
    sequence s_settle;
        !config_valid_out [*4] ##[1:4] config_valid_out;
    endsequence
    a_capture_timing: assert property ($rose(rst_n_in) |-> s_settle)
        else $error("configuration not valid in time after reset");
    a_pins_released: assert property ($rose(config_valid_out) |-> ##[0:2] strap_pins_released_out)
        else $error("strap pins not released after capture");
    a_pll_power_sel: assert property (up_cnt == 3'h7 |-> second_pll_power_out == second_pll_clock_select_out)
        else $error("second pll power differs from its selection");
    a_ref_when_off: assert property (up_cnt == 3'h7 && !second_pll_clock_select_out
                                     |-> second_pll_ref_out == BSCD_REF_F125)
        else $error("reference shown while second pll is off");
    a_slave_vs_flash: assert property (up_cnt == 3'h7 |-> serial_slave_enable_out != serial_flash_master_out)
        else $error("serial slave and flash master both on or both off");
    a_flash_write: assert property (s_wr_ctrl |-> ##2 serial_flash_master_out == $past(reg_wdata_in[0], 2))
        else $error("flash master does not follow control write");
    a_mgmt_write: assert property (s_wr_ctrl |-> ##2 management_slave_enable_out == $past(reg_wdata_in[4], 2))
        else $error("management slave does not follow control write");
    a_strap_hi_level: assert property (boot_strap_hi_oe_n_out == 2'h0 |-> boot_strap_hi_out == 2'h3)
        else $error("upper strap pins driven but not high");
    a_strap_hi_hold: assert property (boot_strap_hi_oe_n_out == 2'h0 |=> boot_strap_hi_oe_n_out == 2'h0)
        else $error("upper strap pin drive dropped");
    a_tap_follow: assert property (up_cnt == 3'h7 && $past(debug_tap_select_n_in, 3) == debug_tap_select_n_in
        && $past(debug_tap_select_n_in, 1) == debug_tap_select_n_in |-> tap_boundary_scan_out == debug_tap_select_n_in)
        else $error("debug port routing does not follow select pin");
    a_unmapped_read: assert property (reg_rd_in && reg_addr_in > 4'h2 |=> reg_rdata_out == 32'h0)
        else $error("unmapped read returned data");
endmodule
bind bscd_top bscd_top_assertions u_bscd_top_assertions (.*);
`default_nettype wire

// ---- bscd_top_tb.sv ----
`default_nettype none
module bscd_top_tb import bscd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic        second_pll_select_strap_in = 1'b0, debug_tap_select_n_in = 1'b0;
    logic [2:0]  main_pll_ref_freq_strap_in = 3'h0, second_pll_ref_freq_strap_in = 3'h0;
    logic [3:0]  boot_strap_in = 4'h0, reg_addr_in = 4'h0;
    logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
    logic [1:0]  port_ready_in, boot_strap_hi_out, boot_strap_hi_oe_n_out;
    logic [2:0]  main_pll_ref_out;
    logic [4:0]  management_slave_addr_out;
    bscd_ref_t   second_pll_ref_out;
    logic        config_valid_out, strap_pins_released_out, second_pll_clock_select_out, second_pll_power_out;
    logic        pcie_enable_out, front_port10_sfi_out, front_port6_sgmii_out, front_port0_sgmii_out;
    logic        npi_port4_sgmii_out, npi_port9_sfi_out, register_access_frames_out, serial_slave_enable_out;
    logic        management_slave_enable_out, cpu_run_out, cpu_big_endian_out, boot_map_enable_out;
    logic        serial_flash_master_out, tap_boundary_scan_out;
    int          fail_count = 0, n_checks = 0;
    wire logic [10:0] dec_vec = {pcie_enable_out, front_port10_sfi_out, front_port6_sgmii_out,
        front_port0_sgmii_out, npi_port4_sgmii_out, npi_port9_sfi_out, register_access_frames_out,
        serial_slave_enable_out, management_slave_enable_out, cpu_run_out, cpu_big_endian_out};
    wire logic [5:0]  host_vec = {serial_flash_master_out, serial_slave_enable_out, cpu_run_out,
        boot_map_enable_out, cpu_big_endian_out, management_slave_enable_out};
    localparam logic [3:0]  CODES [12] = '{4'h0, 4'hC, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA, 4'hB, 4'hF};
    localparam logic [10:0] DECS [12] = '{11'h002, 11'h003, 11'h658, 11'h558, 11'h4D8, 11'h638, 11'h438,
                                          11'h458, 11'h408, 11'h00C, 11'h00C, 11'h008};
    localparam logic [7:0]  GCS [12] = '{8'h03, 8'h0B, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04,
                                         8'h14, 8'h14, 8'h04};
    localparam logic [2:0]  REFS [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3};
    localparam bscd_ref_t   REFE [5] = '{BSCD_REF_F125, BSCD_REF_F156P25, BSCD_REF_F250, BSCD_REF_F25,
                                         BSCD_REF_RESERVED};
    bscd_top u_bscd_top (.*);
    bscd_port_model u_bscd_port_model (
        .mclk_in    (mclk_in),
        .rst_n_in   (rst_n_in),
        .link_up_in (pcie_enable_out | front_port10_sfi_out | front_port6_sgmii_out | front_port0_sgmii_out),
        .ready_out  (port_ready_in)
    );
    initial begin
        forever #5 mclk_in = ~mclk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= 1'b1;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        reg_addr_in <= a;
        reg_rd_in   <= 1'b1;
        @(posedge mclk_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, e);
    endtask
    task automatic host(input logic [31:0] d, input logic [5:0] e);
        wr_reg(4'h0, d);
        @(posedge mclk_in);
        #1;
        chk(32'(host_vec), 32'(e));
    endtask
    task automatic pulse_reset;
        int k;
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        k = 0;
        while (config_valid_out !== 1'b1 && k < 20) begin
            @(posedge mclk_in);
            #1;
            k++;
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_in);
        fail_count++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge mclk_in);
        for (int i = 0; i < 12; i++) begin
            boot_strap_in                <= CODES[i];
            second_pll_select_strap_in   <= i[0];
            second_pll_ref_freq_strap_in <= REFS[i % 5];
            main_pll_ref_freq_strap_in   <= 3'(i);
            pulse_reset();
            chk(32'(config_valid_out), 32'h1);
            boot_strap_in                <= ~CODES[i];
            second_pll_select_strap_in   <= ~i[0];
            second_pll_ref_freq_strap_in <= ~REFS[i % 5];
            main_pll_ref_freq_strap_in   <= ~3'(i);
            repeat (3) @(posedge mclk_in);
            #1;
            chk(32'(dec_vec), 32'(DECS[i]));
            if (CODES[i][3:1] == 3'h5) chk(32'(management_slave_addr_out), {27'h0, {5{CODES[i][0]}}});
            chk({30'h0, second_pll_clock_select_out, second_pll_power_out}, {30'h0, i[0], i[0]});
            chk(32'(second_pll_ref_out), i[0] ? 32'(REFE[i % 5]) : 32'(BSCD_REF_F125));
            chk({28'h0, main_pll_ref_out, strap_pins_released_out}, {28'h0, 3'(i), 1'b1});
            rd_chk(4'h0, 32'(GCS[i]));
            rd_chk(4'h1, {21'h0, REFS[i % 5], 3'(i), i[0], CODES[i]});
            repeat (8) @(posedge mclk_in);
            #1;
            chk(32'(boot_strap_hi_oe_n_out), DECS[i][10] ? 32'h0 : 32'h3);
            if (DECS[i][10]) chk(32'(boot_strap_hi_out), 32'h3);
            rd_chk(4'h2, {29'h0, DECS[i][10], 2'h2});
            $display("test strap code %h done", CODES[i]);
        end
        host(32'h03, 6'b101100);
        host(32'h08, 6'b011010);
        host(32'h14, 6'b010001);
        rd_chk(4'h0, 32'h14);
        wr_reg(4'h1, 32'hFFFF_FFFF);
        rd_chk(4'h1, 32'h17F);
        rd_chk(4'h7, 32'h0);
        $display("test host control done");
        @(posedge mclk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        wr_reg(4'h0, 32'h10);
        repeat (8) @(posedge mclk_in);
        rd_chk(4'h0, 32'h03);
        for (int t = 1; t >= 0; t--) begin
            debug_tap_select_n_in <= t[0];
            repeat (4) @(posedge mclk_in);
            #1;
            chk(32'(tap_boundary_scan_out), 32'(t[0]));
        end
        $display("test early write and debug select done");
        summarize();
    end
endmodule
`default_nettype wire
